// *** rtl/ipei_input_port.sv ***
`timescale 1ns/1ps
`include "ipei_defines.svh"
//
// Contract
// - reading a levels register returns the four current pin levels
// - levels registers are read-only; writes change nothing
// - select bit 1 includes the pin in the group condition, 0 excludes it
// - compare bit 1 selects falling edge, 0 selects rising edge
// - comparison covers only pins enabled by the group's select bits
// - condition fires when enabled pins go from all matching to a mismatch
// - mismatch to another mismatch raises no new condition
// - each group has a mask bit: 1 enables delivery, 0 masks
// - one pending flag per group; reads 1 when a condition occurred
// - pending flag sets on condition regardless of mask
// - masked group never asserts its request, even with flag set
// - writing 1 clears a pending flag; writing 0 does nothing
// - uncleared flag keeps requesting, so the interrupt recurs
// - reset clears select, compare and mask bits
// - reset clears both pending flags
// - unused bits of mask and pending registers read zero
// - top pin of second group also drives the timer clock input
//
module ipei_input_port
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire ipei_pkg::ipei_addr_type  s_axi_awaddr,
    input  wire logic                     s_axi_awvalid,
    output      logic                     s_axi_awready,
    input  wire ipei_pkg::ipei_word_type  s_axi_wdata,
    input  wire logic [3:0]               s_axi_wstrb,
    input  wire logic                     s_axi_wvalid,
    output      logic                     s_axi_wready,
    output      logic [1:0]               s_axi_bresp,
    output      logic                     s_axi_bvalid,
    input  wire logic                     s_axi_bready,
    input  wire ipei_pkg::ipei_addr_type  s_axi_araddr,
    input  wire logic                     s_axi_arvalid,
    output      logic                     s_axi_arready,
    output      ipei_pkg::ipei_word_type  s_axi_rdata,
    output      logic [1:0]               s_axi_rresp,
    output      logic                     s_axi_rvalid,
    input  wire logic                     s_axi_rready,
    input  wire ipei_pkg::ipei_nibble_type firstGroupPins,
    input  wire ipei_pkg::ipei_nibble_type secondGroupPins,
    output      logic                     firstGroupIrq,
    output      logic                     secondGroupIrq,
    output      logic                     timerClockSharedPin
);
    import ipei_pkg::*;

    ipei_nibble_type firstGroupSelect_r;
    ipei_nibble_type secondGroupSelect_r;
    ipei_nibble_type firstGroupEdgeCompare_r;
    ipei_nibble_type secondGroupEdgeCompare_r;
    logic            firstGroupIrqEnable_r;
    logic            secondGroupIrqEnable_r;
    logic            firstGroupIrqPending_r;
    logic            secondGroupIrqPending_r;
    ipei_nibble_type firstLevels;
    ipei_nibble_type secondLevels;
    logic            firstEvent;
    logic            secondEvent;

    ipei_wstate_type wState_r;
    ipei_addr_type   awAddr_r;
    logic            awHeld_r;
    ipei_word_type   wData_r;
    logic [3:0]      wStrb_r;
    logic            wHeld_r;
    logic [1:0]      bResp_r;
    ipei_word_type   rData_r;
    logic [1:0]      rResp_r;
    logic            rValid_r;
    logic            doWrite;
    logic            wrHit;
    ipei_addr_type   wIdx;
    ipei_addr_type   rIdx;
    logic            lane0;
    logic            wrSelA;
    logic            wrCmpA;
    logic            wrSelB;
    logic            wrCmpB;
    logic            wrEnA;
    logic            wrEnB;
    logic            clrPendA;
    logic            clrPendB;

    ipei_group_detect u_first
    (
        .clk         (clk),
        .arst_n      (arst_n),
        .pinsAsync   (firstGroupPins),
        .selectBits  (firstGroupSelect_r),
        .compareBits (firstGroupEdgeCompare_r),
        .pinLevels   (firstLevels),
        .condEvent   (firstEvent)
    );

    ipei_group_detect u_second
    (
        .clk         (clk),
        .arst_n      (arst_n),
        .pinsAsync   (secondGroupPins),
        .selectBits  (secondGroupSelect_r),
        .compareBits (secondGroupEdgeCompare_r),
        .pinLevels   (secondLevels),
        .condEvent   (secondEvent)
    );

    // timer sees the synchronised pin; its group condition still applies
    assign timerClockSharedPin = secondLevels[`IPEI_TIMER_PIN_BIT];

    // ---------------- write channel ----------------
    assign s_axi_awready = (wState_r == IPEI_W_IDLE) && !awHeld_r;
    assign s_axi_wready  = (wState_r == IPEI_W_IDLE) && !wHeld_r;
    assign s_axi_bvalid  = (wState_r == IPEI_W_RESP);
    assign s_axi_bresp   = bResp_r;
    assign doWrite       = (wState_r == IPEI_W_IDLE) && awHeld_r && wHeld_r;
    assign wIdx          = {2'b00, awAddr_r[`IPEI_ADDR_W-1:2]};
    assign lane0         = wStrb_r[0];

    // address and data may arrive in either order; each is held until both are in
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            awHeld_r <= 1'b0;
            awAddr_r <= '0;
            wHeld_r  <= 1'b0;
            wData_r  <= '0;
            wStrb_r  <= 4'h0;
        end
        else if (doWrite)
        begin
            awHeld_r <= 1'b0;
            wHeld_r  <= 1'b0;
        end
        else
        begin
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld_r <= 1'b1;
                awAddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wStrb_r <= s_axi_wstrb;
            end
        end
    end

    // one strobe per register; a cleared lane 0 turns the write into a no-op
    always_comb
    begin
        wrHit    = 1'b1;
        wrSelA   = 1'b0;
        wrCmpA   = 1'b0;
        wrSelB   = 1'b0;
        wrCmpB   = 1'b0;
        wrEnA    = 1'b0;
        wrEnB    = 1'b0;
        clrPendA = 1'b0;
        clrPendB = 1'b0;
        if (wIdx == `IPEI_IDX_A_SELECT)
        begin
            wrSelA = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_A_LEVELS)
        begin
            wrHit = 1'b1;                       // answered, nothing stored
        end
        else if (wIdx == `IPEI_IDX_A_COMPARE)
        begin
            wrCmpA = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_B_SELECT)
        begin
            wrSelB = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_B_LEVELS)
        begin
            wrHit = 1'b1;
        end
        else if (wIdx == `IPEI_IDX_B_COMPARE)
        begin
            wrCmpB = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_A_ENABLE)
        begin
            wrEnA = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_B_ENABLE)
        begin
            wrEnB = doWrite && lane0;
        end
        else if (wIdx == `IPEI_IDX_A_PENDING)
        begin
            clrPendA = doWrite && lane0 && wData_r[`IPEI_FLAG_BIT];
        end
        else if (wIdx == `IPEI_IDX_B_PENDING)
        begin
            clrPendB = doWrite && lane0 && wData_r[`IPEI_FLAG_BIT];
        end
        else
        begin
            wrHit = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wState_r <= IPEI_W_IDLE;
            bResp_r  <= `IPEI_RESP_OKAY;
        end
        else
        begin
            case (wState_r)
                IPEI_W_IDLE:
                begin
                    if (doWrite)
                    begin
                        wState_r <= IPEI_W_RESP;
                        bResp_r  <= wrHit ? `IPEI_RESP_OKAY : `IPEI_RESP_SLVERR;
                    end
                end
                default:
                begin
                    if (s_axi_bready)
                        wState_r <= IPEI_W_IDLE;
                end
            endcase
        end
    end

    // control registers; levels registers have no write path
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstGroupSelect_r       <= `IPEI_RST_SELECT;
            secondGroupSelect_r      <= `IPEI_RST_SELECT;
            firstGroupEdgeCompare_r  <= `IPEI_RST_COMPARE;
            secondGroupEdgeCompare_r <= `IPEI_RST_COMPARE;
            firstGroupIrqEnable_r    <= `IPEI_RST_FLAG;
            secondGroupIrqEnable_r   <= `IPEI_RST_FLAG;
        end
        else
        begin
            if (wrSelA)
                firstGroupSelect_r <= wData_r[3:0];
            if (wrCmpA)
                firstGroupEdgeCompare_r <= wData_r[3:0];
            if (wrSelB)
                secondGroupSelect_r <= wData_r[3:0];
            if (wrCmpB)
                secondGroupEdgeCompare_r <= wData_r[3:0];
            if (wrEnA)
                firstGroupIrqEnable_r <= wData_r[`IPEI_FLAG_BIT];
            if (wrEnB)
                secondGroupIrqEnable_r <= wData_r[`IPEI_FLAG_BIT];
        end
    end
    // writes to the levels indices fall through the chain above untouched

    // set wins over a same-cycle write-1 clear, so no event is lost
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            firstGroupIrqPending_r  <= `IPEI_RST_FLAG;
            secondGroupIrqPending_r <= `IPEI_RST_FLAG;
        end
        else
        begin
            if (firstEvent)
                firstGroupIrqPending_r <= 1'b1;
            else if (clrPendA)
                firstGroupIrqPending_r <= 1'b0;
            if (secondEvent)
                secondGroupIrqPending_r <= 1'b1;
            else if (clrPendB)
                secondGroupIrqPending_r <= 1'b0;
        end
    end

    // level request: stays up until the flag is cleared, so it recurs
    assign firstGroupIrq  = firstGroupIrqPending_r & firstGroupIrqEnable_r;
    assign secondGroupIrq = secondGroupIrqPending_r & secondGroupIrqEnable_r;

    // ---------------- read channel ----------------
    assign s_axi_arready = !rValid_r;
    assign s_axi_rvalid  = rValid_r;
    assign s_axi_rdata   = rData_r;
    assign s_axi_rresp   = rResp_r;
    assign rIdx          = {2'b00, s_axi_araddr[`IPEI_ADDR_W-1:2]};

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rValid_r <= 1'b0;
            rData_r  <= '0;
            rResp_r  <= `IPEI_RESP_OKAY;
        end
        else if (rValid_r)
        begin
            if (s_axi_rready)
                rValid_r <= 1'b0;
        end
        else if (s_axi_arvalid)
        begin
            rValid_r <= 1'b1;
            rResp_r  <= `IPEI_RESP_OKAY;
            rData_r  <= '0;
            if (rIdx == `IPEI_IDX_A_SELECT)
                rData_r[3:0] <= firstGroupSelect_r;
            else if (rIdx == `IPEI_IDX_A_LEVELS)
                rData_r[3:0] <= firstLevels;
            else if (rIdx == `IPEI_IDX_A_COMPARE)
                rData_r[3:0] <= firstGroupEdgeCompare_r;
            else if (rIdx == `IPEI_IDX_B_SELECT)
                rData_r[3:0] <= secondGroupSelect_r;
            else if (rIdx == `IPEI_IDX_B_LEVELS)
                rData_r[3:0] <= secondLevels;
            else if (rIdx == `IPEI_IDX_B_COMPARE)
                rData_r[3:0] <= secondGroupEdgeCompare_r;
            else if (rIdx == `IPEI_IDX_A_ENABLE)
                rData_r[`IPEI_FLAG_BIT] <= firstGroupIrqEnable_r;
            else if (rIdx == `IPEI_IDX_B_ENABLE)
                rData_r[`IPEI_FLAG_BIT] <= secondGroupIrqEnable_r;
            else if (rIdx == `IPEI_IDX_A_PENDING)
                rData_r[`IPEI_FLAG_BIT] <= firstGroupIrqPending_r;
            else if (rIdx == `IPEI_IDX_B_PENDING)
                rData_r[`IPEI_FLAG_BIT] <= secondGroupIrqPending_r;
            else
                rResp_r <= `IPEI_RESP_SLVERR;
        end
    end
endmodule

// *** rtl/ipei_defines.svh ***
`ifndef IPEI_DEFINES_SVH
`define IPEI_DEFINES_SVH

// register indices as printed; byte address is four times the index
`define IPEI_IDX_A_SELECT    16'hFF20
`define IPEI_IDX_A_LEVELS    16'hFF21
`define IPEI_IDX_A_COMPARE   16'hFF22
`define IPEI_IDX_B_SELECT    16'hFF24
`define IPEI_IDX_B_LEVELS    16'hFF25
`define IPEI_IDX_B_COMPARE   16'hFF26
`define IPEI_IDX_A_ENABLE    16'hFFE4
`define IPEI_IDX_B_ENABLE    16'hFFE5
`define IPEI_IDX_A_PENDING   16'hFFF4
`define IPEI_IDX_B_PENDING   16'hFFF5

`define IPEI_ADDR_W          18
`define IPEI_PORT_W          4
`define IPEI_FLAG_BIT        0
`define IPEI_TIMER_PIN_BIT   3

`define IPEI_RST_SELECT      4'h0
`define IPEI_RST_COMPARE     4'h0
`define IPEI_RST_FLAG        1'b0

`define IPEI_RESP_OKAY       2'h0
`define IPEI_RESP_SLVERR     2'h2

`endif

// *** rtl/ipei_pkg.sv ***
`include "ipei_defines.svh"

package ipei_pkg;
    typedef logic [`IPEI_PORT_W-1:0] ipei_nibble_type;
    typedef logic [`IPEI_ADDR_W-1:0] ipei_addr_type;
    typedef logic [31:0]             ipei_word_type;
    typedef enum logic [1:0] {
        IPEI_W_IDLE,
        IPEI_W_RESP
    } ipei_wstate_type;
endpackage

// *** rtl/ipei_group_detect.sv ***
`timescale 1ns/1ps
`include "ipei_defines.svh"

module ipei_group_detect
(
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    input  wire ipei_pkg::ipei_nibble_type pinsAsync,
    input  wire ipei_pkg::ipei_nibble_type selectBits,
    input  wire ipei_pkg::ipei_nibble_type compareBits,
    output      ipei_pkg::ipei_nibble_type pinLevels,
    output      logic                     condEvent
);
    import ipei_pkg::*;

    ipei_nibble_type syncA_r;
    ipei_nibble_type syncB_r;
    logic            match_r;
    logic            matchNow;

    // first stage feeds only the second
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            syncA_r <= 4'h0;
            syncB_r <= 4'h0;
        end
        else
        begin
            syncA_r <= pinsAsync;
            syncB_r <= syncA_r;
        end
    end

    assign pinLevels = syncB_r;

    // all selected pins equal their compare bit; unselected pins ignored
    always_comb
    begin
        matchNow = &(~selectBits | ~(syncB_r ^ compareBits));
    end

    // start as matching so reset alone never flags
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            match_r <= 1'b1;
        end
        else
        begin
            match_r <= matchNow;
        end
    end

    // only match to mismatch counts; mismatch to other mismatch does not
    assign condEvent = match_r & ~matchNow;
endmodule

// *** verif/ipei_input_port_sva.sv ***
`timescale 1ns/1ps
`include "ipei_defines.svh"
module ipei_input_port_sva
(
    input wire logic                      clk,
    input wire logic                      arst_n,
    input wire ipei_pkg::ipei_addr_type   s_axi_awaddr,
    input wire logic                      s_axi_awvalid,
    input wire logic                      s_axi_awready,
    input wire ipei_pkg::ipei_word_type   s_axi_wdata,
    input wire logic [3:0]                s_axi_wstrb,
    input wire logic                      s_axi_wvalid,
    input wire logic                      s_axi_wready,
    input wire logic [1:0]                s_axi_bresp,
    input wire logic                      s_axi_bvalid,
    input wire logic                      s_axi_bready,
    input wire ipei_pkg::ipei_addr_type   s_axi_araddr,
    input wire logic                      s_axi_arvalid,
    input wire logic                      s_axi_arready,
    input wire ipei_pkg::ipei_word_type   s_axi_rdata,
    input wire logic [1:0]                s_axi_rresp,
    input wire logic                      s_axi_rvalid,
    input wire logic                      s_axi_rready,
    input wire ipei_pkg::ipei_nibble_type firstGroupPins,
    input wire ipei_pkg::ipei_nibble_type secondGroupPins,
    input wire logic                      firstGroupIrq,
    input wire logic                      secondGroupIrq,
    input wire logic                      timerClockSharedPin
);
    import ipei_pkg::*;
    default clocking dcb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    ipei_nibble_type prevA_r;
    logic [2:0]      stA_r;
    logic [15:0]     rdIdx_r;
    // how long the first group has held still; the synchroniser needs two edges
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n)
            stA_r <= 3'h0;
        else if (firstGroupPins != prevA_r)
            stA_r <= 3'h0;
        else if (stA_r != 3'h7)
            stA_r <= stA_r + 3'h1;
    always_ff @(posedge clk)
        prevA_r <= firstGroupPins;
    always_ff @(posedge clk)
        if (s_axi_arvalid && s_axi_arready)
            rdIdx_r <= s_axi_araddr[17:2];
    AST_TIMER_PIN: assert property ($stable(secondGroupPins[3]) [*4]
        |-> timerClockSharedPin == secondGroupPins[3])
        else $error("timer pin does not follow the top second-group pin");
    AST_LEVELS_READ: assert property (s_axi_arvalid && s_axi_arready && stA_r > 3'h3
        && s_axi_araddr[17:2] == `IPEI_IDX_A_LEVELS
        |=> s_axi_rdata == {28'h0, $past(firstGroupPins)})
        else $error("levels read differs from the pins");
    AST_UPPER_ZERO: assert property (s_axi_rvalid && s_axi_rresp == `IPEI_RESP_OKAY
        && rdIdx_r[7:5] == 3'h7 |-> s_axi_rdata[31:1] == 31'h0)
        else $error("unused mask or flag bits read nonzero");
    AST_IRQ_FALL: assert property ($fell(firstGroupIrq) || $fell(secondGroupIrq)
        |-> $rose(s_axi_bvalid))
        else $error("request dropped without a register write");
    AST_IRQ_RESET: assert property ($rose(arst_n) |-> !firstGroupIrq && !secondGroupIrq)
        else $error("request active straight after reset");
    AST_RD_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    AST_WR_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    AST_RD_BLOCK: assert property (s_axi_rvalid && s_axi_rready
        |-> !s_axi_arready ##1 !s_axi_rvalid)
        else $error("read answer accepted twice or taken while pending");
endmodule
bind ipei_input_port ipei_input_port_sva ipei_input_port_sva_i (.*);

// *** verif/ipei_key_model.sv ***
`timescale 1ns/1ps
module ipei_key_model
(
    input  wire logic                      clk,
    input  wire ipei_pkg::ipei_nibble_type levA,
    input  wire ipei_pkg::ipei_nibble_type levB,
    output      ipei_pkg::ipei_nibble_type firstGroupPins = 4'hF,
    output      ipei_pkg::ipei_nibble_type secondGroupPins = 4'hF
);
    import ipei_pkg::*;
    // keys idle high on their pull-ups; contact bounce is not modelled
    always @(posedge clk)
    begin
        firstGroupPins  <= levA;
        secondGroupPins <= levB;
    end
endmodule

// *** verif/test_input_port_edge_interrupt.sv ***
`timescale 1ns/1ps
`include "ipei_defines.svh"
module test_input_port_edge_interrupt;
    import ipei_pkg::*;
    logic            clk = 1'b0;
    logic            arst_n = 1'b0;
    ipei_addr_type   s_axi_awaddr = '0, s_axi_araddr = '0;
    ipei_word_type   s_axi_wdata = '0, s_axi_rdata;
    logic [3:0]      s_axi_wstrb = 4'hF;
    logic            s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic            s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic            s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]      s_axi_bresp, s_axi_rresp;
    ipei_nibble_type firstGroupPins, secondGroupPins;
    ipei_nibble_type levA = 4'hF, levB = 4'hF;
    logic            firstGroupIrq, secondGroupIrq, timerClockSharedPin;
    logic [33:0]     got;
    logic [2:0]      outsSeen;
    int              err_total = 0, num_checks = 0, cyc = 0;
    logic [15:0]     cfgIdx [8] = '{`IPEI_IDX_A_SELECT, `IPEI_IDX_A_COMPARE, `IPEI_IDX_B_SELECT,
        `IPEI_IDX_B_COMPARE, `IPEI_IDX_A_ENABLE, `IPEI_IDX_B_ENABLE, `IPEI_IDX_A_PENDING,
        `IPEI_IDX_B_PENDING};

    ipei_input_port ipei_input_port_i (.*);
    ipei_key_model ipei_key_model_i (.clk(clk), .levA(levA), .levB(levB),
        .firstGroupPins(firstGroupPins), .secondGroupPins(secondGroupPins));

    initial
        forever #50 clk = ~clk;

    // outputs as they stand before the next edge, clear of the edge race
    always @(negedge clk)
        outsSeen <= {timerClockSharedPin, secondGroupIrq, firstGroupIrq};

    task automatic test_done;
        if (err_total == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("[FAIL] %s exp %h got %h", nm, e, g);
            err_total++;
        end
    endtask

    // handshakes are judged on settled values, then acted on at the taking edge
    task automatic wr(input logic [15:0] idx, input ipei_word_type d);
        logic awTake;
        logic wTake;
        logic bTake;
        bTake          = 1'b0;
        s_axi_awaddr  <= {idx, 2'b00};
        s_axi_wdata   <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        while (!bTake)
        begin
            @(negedge clk);
            awTake = s_axi_awvalid && s_axi_awready;
            wTake  = s_axi_wvalid && s_axi_wready;
            bTake  = s_axi_bvalid;
            got    = {s_axi_bresp, 32'h0};
            @(posedge clk);
            if (awTake)
                s_axi_awvalid <= 1'b0;
            if (wTake)
                s_axi_wvalid <= 1'b0;
        end
    endtask

    task automatic rd(input logic [15:0] idx);
        logic arTake;
        logic rTake;
        rTake          = 1'b0;
        s_axi_araddr  <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        while (!rTake)
        begin
            @(negedge clk);
            arTake = s_axi_arvalid && s_axi_arready;
            rTake  = s_axi_rvalid;
            got    = {s_axi_rresp, s_axi_rdata};
            @(posedge clk);
            if (arTake)
                s_axi_arvalid <= 1'b0;
        end
    endtask

    task automatic rc(input logic [15:0] idx, input logic [3:0] e);
        rd(idx);
        chk("register", {30'h0, e}, got);
    endtask

    // pins reach the pending flag a few edges after they move; wait past that
    task automatic pins(input ipei_nibble_type a, input ipei_nibble_type b);
        levA <= a;
        levB <= b;
        repeat (8) @(posedge clk);
    endtask

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_total++;
            test_done;
        end
    end

    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        foreach (cfgIdx[i])
            rc(cfgIdx[i], 4'h0);
        for (int i = 0; i < 6; i++)
        begin
            wr(cfgIdx[i], 32'hFFFF_FFF5);
            chk("write response", `IPEI_RESP_OKAY, got[33:32]);
            rc(cfgIdx[i], (i < 4) ? 4'h5 : 4'h1);
            wr(cfgIdx[i], 32'h0);
        end
        // lane 0 off: the word is answered but must not land
        s_axi_wstrb <= 4'hE;
        wr(`IPEI_IDX_A_SELECT, 32'h0000_000F);
        s_axi_wstrb <= 4'hF;
        rc(`IPEI_IDX_A_SELECT, 4'h0);
        rd(16'hFF23);
        chk("unmapped read", `IPEI_RESP_SLVERR, got[33:32]);
        wr(16'hFF23, 32'h0000_000F);
        chk("unmapped write", `IPEI_RESP_SLVERR, got[33:32]);
        pins(4'h9, 4'h6);
        rc(`IPEI_IDX_A_LEVELS, 4'h9);
        rc(`IPEI_IDX_B_LEVELS, 4'h6);
        chk("timer pin", 34'h0, outsSeen[2]);
        wr(`IPEI_IDX_A_LEVELS, 32'h0000_0006);
        rc(`IPEI_IDX_A_LEVELS, 4'h9);
        pins(4'hE, 4'h6);
        wr(`IPEI_IDX_A_SELECT, 32'hE);
        wr(`IPEI_IDX_A_COMPARE, 32'hE);
        // a config change may itself raise the flag, so clear it first
        wr(`IPEI_IDX_A_PENDING, 32'h1);
        pins(4'hF, 4'h6);
        rc(`IPEI_IDX_A_PENDING, 4'h0);
        pins(4'hB, 4'h6);
        rc(`IPEI_IDX_A_PENDING, 4'h1);
        chk("masked request", 34'h0, outsSeen[0]);
        wr(`IPEI_IDX_A_PENDING, 32'h1);
        rc(`IPEI_IDX_A_PENDING, 4'h0);
        pins(4'h9, 4'h6);
        rc(`IPEI_IDX_A_PENDING, 4'h0);
        pins(4'hF, 4'h6);
        pins(4'h7, 4'h6);
        wr(`IPEI_IDX_A_PENDING, 32'h0);
        rc(`IPEI_IDX_A_PENDING, 4'h1);
        wr(`IPEI_IDX_A_ENABLE, 32'h1);
        rc(`IPEI_IDX_B_LEVELS, 4'h6);
        chk("request held", 34'h1, outsSeen[0]);
        wr(`IPEI_IDX_A_PENDING, 32'h1);
        chk("request cleared", 34'h0, outsSeen[0]);
        wr(`IPEI_IDX_B_SELECT, 32'h1);
        wr(`IPEI_IDX_B_ENABLE, 32'h1);
        wr(`IPEI_IDX_B_PENDING, 32'h1);
        chk("second idle", 34'h0, outsSeen[1]);
        pins(4'h7, 4'hF);
        chk("second request", 34'h1, outsSeen[1]);
        chk("timer pin", 34'h1, outsSeen[2]);
        rc(`IPEI_IDX_B_PENDING, 4'h1);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        chk("request after reset", 34'h0, outsSeen[1]);
        rc(`IPEI_IDX_B_ENABLE, 4'h0);
        rc(`IPEI_IDX_B_PENDING, 4'h0);
        test_done;
    end
endmodule
